// file: verilog/boot_map_pkg.sv
package boot_map_pkg;

   // Memory-size variants
   localparam int VARIANT_SMALL = 0;
   localparam int VARIANT_MID   = 1;
   localparam int VARIANT_LARGE = 2;

   // Program counter and word-in-page widths per variant
   localparam int PC_BITS_SMALL   = 12;
   localparam int PC_BITS_MID     = 13;
   localparam int PC_BITS_LARGE   = 14;
   localparam int WORD_BITS_SMALL = 5;
   localparam int WORD_BITS_MID   = 6;
   localparam int WORD_BITS_LARGE = 6;

   // First word of the halting section per variant
   localparam logic [15:0] HALT_START_SMALL = 16'h0C00;
   localparam logic [15:0] HALT_START_MID   = 16'h1C00;
   localparam logic [15:0] HALT_START_LARGE = 16'h3800;

   // Boot section size for fuse code 00; each code step halves it
   localparam logic [15:0] BOOT_WORDS_MAX_SMALL = 16'h0400;
   localparam logic [15:0] BOOT_WORDS_MAX_LARGE = 16'h0800;

   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_POINTER = 8'h04;
   localparam logic [7:0] ADDR_DATA    = 8'h08;
   localparam logic [7:0] ADDR_STORE   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_LOAD    = 8'h14;

   // Control and status register fields, the idle control value and legal command codes
   localparam int BIT_BUSY        = 6;
   localparam int STATUS_CODE_LSB = 16;
   localparam int STATUS_HALT     = 18;
   localparam int STATUS_EEPROM   = 19;
   localparam int STATUS_VAR_LSB  = 20;
   localparam logic [4:0] CTRL_RESET   = 5'h00;
   localparam logic [4:0] CMD_FILL     = 5'h01;
   localparam logic [4:0] CMD_ERASE    = 5'h03;
   localparam logic [4:0] CMD_WRITE    = 5'h05;
   localparam logic [4:0] CMD_LOCK     = 5'h09;
   localparam logic [4:0] CMD_REENABLE = 5'h11;

   // Store instruction arming window, in clock cycles
   localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

   // Least programming time and the derived cycle count
   localparam int CLK_PERIOD_NS  = 8;
   localparam int PROG_TIME_NS   = 3700000;
   localparam int PROG_CYCLES    = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   function automatic int pc_bits(input int v);
      return (v == VARIANT_SMALL) ? PC_BITS_SMALL :
             (v == VARIANT_MID)   ? PC_BITS_MID   : PC_BITS_LARGE;
   endfunction

   function automatic int word_bits(input int v);
      return (v == VARIANT_SMALL) ? WORD_BITS_SMALL :
             (v == VARIANT_MID)   ? WORD_BITS_MID   : WORD_BITS_LARGE;
   endfunction

   function automatic logic [15:0] halt_start(input int v);
      return (v == VARIANT_SMALL) ? HALT_START_SMALL :
             (v == VARIANT_MID)   ? HALT_START_MID   : HALT_START_LARGE;
   endfunction

endpackage

// file: verilog/page_buffer_mem.sv
module page_buffer_mem #(
   parameter int WIDTH  = 16,
   parameter int ADDR_W = 6
) (
   input  wire logic              clk_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] waddr_i,
   input  wire logic [WIDTH-1:0]  wdata_i,
   input  wire logic [ADDR_W-1:0] raddr_i,
   output logic      [WIDTH-1:0]  rdata_o
);

   logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   // No reset: buffer contents are undefined until filled
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule // page_buffer_mem

// file: verilog/flash_op_timer.sv
module flash_op_timer #(
   parameter int CYCLES = 4
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic start_i,
   output logic      done_o
);

   logic [31:0] count;
   logic        running;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count   <= 32'h00000000;
         running <= 1'b0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            count   <= 32'(CYCLES - 1);
            running <= 1'b1;
         end else if (running) begin
            if (count == 32'h00000000) begin
               running <= 1'b0;
               done_o  <= 1'b1;
            end else begin
               count <= count - 32'h00000001;
            end
         end
      end
   end

endmodule // flash_op_timer

// file: verilog/boot_section_address_map.sv
// Operation
// - Small variant: fuse code picks boot 128..1024 words
// - Middle variant: fuse code picks boot 128..1024 words
// - Large variant: fuse code picks boot 256..2048 words
// - Small: concurrent below 0xC00, halting above
// - Middle: concurrent below 0x1C00, halting above
// - Large: concurrent below 0x3800, halting above
// - Small: page bits 12:6, word bits 5:1
// - Middle: page bits 13:7, word bits 6:1
// - Large: page bits 14:7, word bits 6:1
// - Pointer bits above page field ignored
// - Bit 0 zero on store, byte select on load
// - Page field targets erase/write; word field fills buffer
// - Busy flag set, blocks concurrent reads, cleared by re-enable/fill
// - Enable arms store four cycles, holds during operation
// - Core halted during halting-section erase/write
module boot_section_address_map #(
   parameter int VARIANT     = boot_map_pkg::VARIANT_LARGE,
   parameter int PROG_CYCLES = boot_map_pkg::PROG_CYCLES
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RSTN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        BOOT_SIZE_FUSE_HI_I,
   input  wire logic        BOOT_SIZE_FUSE_LO_I,
   input  wire logic        EEPROM_WRITE_IN_PROGRESS_I,
   input  wire logic [15:0] FETCH_ADDR_I,
   output logic             FETCH_BLOCKED_O,
   output logic             CORE_HALT_O,
   output logic [15:0]      BOOT_RESET_ADDR_O,
   output logic             FLASH_ERASE_O,
   output logic             FLASH_WRITE_O,
   output logic [7:0]       FLASH_PAGE_O
);

   localparam int          PC_BITS   = boot_map_pkg::pc_bits(VARIANT);
   localparam int          WORD_BITS = boot_map_pkg::word_bits(VARIANT);
   localparam int          PAGE_BITS = PC_BITS - WORD_BITS;
   localparam logic [15:0] HALT_FROM = boot_map_pkg::halt_start(VARIANT);
   localparam logic [15:0] FLASH_TOP = 16'(1 << PC_BITS);
   localparam logic [15:0] BOOT_MAX  = (VARIANT == boot_map_pkg::VARIANT_LARGE) ?
                                       boot_map_pkg::BOOT_WORDS_MAX_LARGE :
                                       boot_map_pkg::BOOT_WORDS_MAX_SMALL;

   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_ARMED = 2'b01,
      OP_BUSY  = 2'b10
   } op_type;

   typedef struct packed {
      op_type      op;
      logic [4:0]  ctrl;
      logic        busy_flag;
      logic [2:0]  arm;
      logic        is_write;
      logic [7:0]  page;
      logic        halt;
      logic        start;
      logic [15:0] pointer;
      logic [15:0] data;
      logic        fill_we;
      logic [5:0]  fill_addr;
      logic [15:0] fill_data;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        strap_done;
      logic [1:0]  boot_code;
      logic [15:0] boot_addr;
      logic        fetch_blocked;
      logic        erasing;
      logic        writing;
   } state_type;

   // Page field: pointer bits above it drop out through the mask
   function automatic logic [7:0] page_of(input logic [15:0] ptr);
      logic [15:0] p;
      p = (ptr >> (WORD_BITS + 1)) & 16'((1 << PAGE_BITS) - 1);
      return p[7:0];
   endfunction

   // Word field: bit 0 is byte select and never part of it
   function automatic logic [5:0] word_of(input logic [15:0] ptr);
      logic [15:0] w;
      w = (ptr >> 1) & 16'((1 << WORD_BITS) - 1);
      return w[5:0];
   endfunction

   function automatic logic page_in_halting(input logic [7:0] pg);
      logic [15:0] a;
      a = 16'({8'h00, pg} << WORD_BITS);
      return (a >= HALT_FROM);
   endfunction

   // Fuse code 00 picks the largest boot section, each step up halves it
   function automatic logic [15:0] boot_start(input logic [1:0] code);
      logic [15:0] size;
      case (code)
         2'b00: begin
            size = BOOT_MAX;
         end
         2'b01: begin
            size = BOOT_MAX >> 1;
         end
         2'b10: begin
            size = BOOT_MAX >> 2;
         end
         default: begin
            size = BOOT_MAX >> 3;
         end
      endcase
      return FLASH_TOP - size;
   endfunction

   // Any other code in the low five bits has no effect
   function automatic logic is_legal_cmd(input logic [4:0] c);
      logic ok;
      case (c)
         boot_map_pkg::CMD_FILL,
         boot_map_pkg::CMD_ERASE,
         boot_map_pkg::CMD_WRITE,
         boot_map_pkg::CMD_LOCK,
         boot_map_pkg::CMD_REENABLE: begin
            ok = 1'b1;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // Control word: busy flag beside the command bits
   function automatic logic [31:0] ctrl_word(input logic busy, input logic [4:0] c);
      logic [31:0] v;
      v                         = 32'h00000000;
      v[4:0]                    = c;
      v[boot_map_pkg::BIT_BUSY] = busy;
      return v;
   endfunction

   // Status word: variant, eeprom flag, halt, fuse code and boot start
   function automatic logic [31:0] status_word(input state_type s, input logic ee);
      logic [31:0] v;
      v                                     = 32'h00000000;
      v[15:0]                               = s.boot_addr;
      v[boot_map_pkg::STATUS_CODE_LSB +: 2] = s.boot_code;
      v[boot_map_pkg::STATUS_HALT]          = s.halt;
      v[boot_map_pkg::STATUS_EEPROM]        = ee;
      v[boot_map_pkg::STATUS_VAR_LSB +: 2]  = 2'(VARIANT);
      return v;
   endfunction

   state_type   st;
   state_type   next_st;
   logic        op_done;
   logic [15:0] buf_rdata;
   logic        access;
   logic [4:0]  cmd;

   page_buffer_mem #(
      .WIDTH  (16),
      .ADDR_W (6)
   ) u_page_buffer (
      .clk_i   (CLK_SYS_I),
      .we_i    (st.fill_we),
      .waddr_i (st.fill_addr),
      .wdata_i (st.fill_data),
      .raddr_i (word_of(st.pointer)),
      .rdata_o (buf_rdata)
   );

   flash_op_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_op_timer (
      .clk_i   (CLK_SYS_I),
      .rstn_i  (RSTN_I),
      .start_i (st.start),
      .done_o  (op_done)
   );

   assign access = PSEL_I & PENABLE_I & st.pready;
   assign cmd    = PWDATA_I[4:0];

   always_comb begin
      next_st           = st;
      next_st.start     = 1'b0;
      next_st.fill_we   = 1'b0;
      // One wait state, then the answer for a single cycle
      next_st.pready    = PSEL_I & PENABLE_I & ~st.pready;
      next_st.pslverr   = 1'b0;

      // Fuse straps are caught once, after reset release
      if (!st.strap_done) begin
         next_st.strap_done = 1'b1;
         next_st.boot_code  = {BOOT_SIZE_FUSE_HI_I, BOOT_SIZE_FUSE_LO_I};
         next_st.boot_addr  = boot_start({BOOT_SIZE_FUSE_HI_I, BOOT_SIZE_FUSE_LO_I});
      end

      // Arming window counts down unless a store arrives
      if (st.op == OP_ARMED) begin
         if (st.arm == 3'h1) begin
            next_st.ctrl = boot_map_pkg::CTRL_RESET;
            next_st.op   = OP_IDLE;
         end else begin
            next_st.arm = st.arm - 3'h1;
         end
      end

      if (st.op == OP_BUSY && op_done) begin
         next_st.op   = OP_IDLE;
         next_st.ctrl = boot_map_pkg::CTRL_RESET;
         next_st.halt = 1'b0;
      end

      if (PSEL_I & ~PENABLE_I) begin
         next_st.prdata = 32'h00000000;
      end

      if (next_st.pready) begin
         case (PADDR_I)
            boot_map_pkg::ADDR_CTRL: begin
               next_st.prdata = ctrl_word(st.busy_flag, st.ctrl);
            end
            boot_map_pkg::ADDR_POINTER: begin
               next_st.prdata = {16'h0000, st.pointer};
            end
            boot_map_pkg::ADDR_DATA: begin
               next_st.prdata = {16'h0000, st.data};
            end
            boot_map_pkg::ADDR_STORE: begin
               next_st.prdata = 32'h00000000;
            end
            boot_map_pkg::ADDR_STATUS: begin
               next_st.prdata = status_word(st, EEPROM_WRITE_IN_PROGRESS_I);
            end
            boot_map_pkg::ADDR_LOAD: begin
               // Pointer bit 0 picks the byte of the addressed word
               next_st.prdata = {24'h000000,
                                 st.pointer[0] ? buf_rdata[15:8] : buf_rdata[7:0]};
            end
            default: begin
               next_st.prdata  = 32'h00000000;
               next_st.pslverr = 1'b1;
            end
         endcase
      end

      if (access & PWRITE_I) begin
         case (PADDR_I)
            boot_map_pkg::ADDR_CTRL: begin
               // Ignored while erase or write runs; codes other than fill, erase, write, lock and re-enable do nothing
               if (st.op != OP_BUSY && is_legal_cmd(cmd)) begin
                  next_st.ctrl = cmd;
                  next_st.arm  = boot_map_pkg::ARM_WINDOW_CYCLES;
                  next_st.op   = OP_ARMED;
               end
            end
            boot_map_pkg::ADDR_POINTER: begin
               next_st.pointer = PWDATA_I[15:0];
            end
            boot_map_pkg::ADDR_DATA: begin
               next_st.data = PWDATA_I[15:0];
            end
            boot_map_pkg::ADDR_STORE: begin
               if (st.op == OP_ARMED) begin
                  case (st.ctrl)
                     boot_map_pkg::CMD_FILL: begin
                        next_st.fill_we   = 1'b1;
                        next_st.fill_addr = word_of(st.pointer);
                        next_st.fill_data = st.data;
                        next_st.busy_flag = 1'b0;
                        next_st.ctrl      = boot_map_pkg::CTRL_RESET;
                        next_st.op        = OP_IDLE;
                     end
                     boot_map_pkg::CMD_ERASE,
                     boot_map_pkg::CMD_WRITE: begin
                        next_st.page     = page_of(st.pointer);
                        next_st.is_write = (st.ctrl == boot_map_pkg::CMD_WRITE);
                        // A store on the window's last edge must not lose the command
                        next_st.ctrl     = st.ctrl;
                        next_st.start    = 1'b1;
                        next_st.op       = OP_BUSY;
                        if (page_in_halting(page_of(st.pointer))) begin
                           next_st.halt = 1'b1;
                        end else begin
                           next_st.busy_flag = 1'b1;
                        end
                     end
                     boot_map_pkg::CMD_REENABLE: begin
                        next_st.busy_flag = 1'b0;
                        next_st.ctrl      = boot_map_pkg::CTRL_RESET;
                        next_st.op        = OP_IDLE;
                     end
                     default: begin
                        next_st.ctrl = boot_map_pkg::CTRL_RESET;
                        next_st.op   = OP_IDLE;
                     end
                  endcase
               end
            end
            default: begin
            end
         endcase
      end

      // Reads of the concurrent section are held off while it is busy
      next_st.fetch_blocked = next_st.busy_flag & (FETCH_ADDR_I < HALT_FROM);
      next_st.erasing       = (next_st.op == OP_BUSY) & ~next_st.is_write;
      next_st.writing       = (next_st.op == OP_BUSY) & next_st.is_write;
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign PRDATA_O          = st.prdata;
   assign PREADY_O          = st.pready;
   assign PSLVERR_O         = st.pslverr;
   assign FETCH_BLOCKED_O   = st.fetch_blocked;
   assign CORE_HALT_O       = st.halt;
   assign BOOT_RESET_ADDR_O = st.boot_addr;
   assign FLASH_ERASE_O     = st.erasing;
   assign FLASH_WRITE_O     = st.writing;
   assign FLASH_PAGE_O      = st.page;

endmodule // boot_section_address_map

// file: sim/boot_map_asserts.sv
module boot_map_asserts #(
   parameter int VARIANT     = 2,
   parameter int PROG_CYCLES = 20
) (
   input wire logic        CLK_SYS_I,
   input wire logic        RSTN_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        BOOT_SIZE_FUSE_HI_I,
   input wire logic        BOOT_SIZE_FUSE_LO_I,
   input wire logic [15:0] FETCH_ADDR_I,
   input wire logic        FETCH_BLOCKED_O,
   input wire logic        CORE_HALT_O,
   input wire logic [15:0] BOOT_RESET_ADDR_O,
   input wire logic        FLASH_ERASE_O,
   input wire logic        FLASH_WRITE_O,
   input wire logic [7:0]  FLASH_PAGE_O
);
   localparam logic [15:0] HALT_ST = boot_map_pkg::halt_start(VARIANT);
   localparam logic [15:0] HALT_PG = HALT_ST >> boot_map_pkg::word_bits(VARIANT);
   localparam logic [15:0] TOP     = 16'(1 << boot_map_pkg::pc_bits(VARIANT));
   localparam logic [15:0] MAXW    = (VARIANT == boot_map_pkg::VARIANT_LARGE) ?
                                     boot_map_pkg::BOOT_WORDS_MAX_LARGE :
                                     boot_map_pkg::BOOT_WORDS_MAX_SMALL;
   logic        op;
   logic [31:0] cnt;
   logic [15:0] exp_boot;
   assign op       = FLASH_ERASE_O | FLASH_WRITE_O;
   assign exp_boot = TOP - (MAXW >> {BOOT_SIZE_FUSE_HI_I, BOOT_SIZE_FUSE_LO_I});
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) cnt <= '0;
      else cnt <= op ? cnt + 1 : '0;
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   sequence s_setup; PSEL_I && !PENABLE_I; endsequence
   sequence s_answer; !PREADY_O ##1 PREADY_O; endsequence
   sequence s_fuse_latched; $rose(RSTN_I); endsequence
   a_ready_wait: assert property (s_setup |=> s_answer) else $error("ready timing");
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
   a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
   a_boot_addr: assert property (s_fuse_latched |=> BOOT_RESET_ADDR_O == exp_boot)
      else $error("boot address wrong");
   a_halt_page: assert property (CORE_HALT_O |-> {8'h00, FLASH_PAGE_O} >= HALT_PG)
      else $error("halt outside section");
   a_halt_op: assert property (CORE_HALT_O |-> op) else $error("halt without op");
   a_fetch_block: assert property (FETCH_BLOCKED_O |-> $past(FETCH_ADDR_I) < HALT_ST)
      else $error("halting fetch blocked");
   a_page_stable: assert property (op && $past(op) |-> $stable(FLASH_PAGE_O))
      else $error("page moved in op");
   a_op_length: assert property ($fell(op) |-> cnt >= PROG_CYCLES && cnt <= PROG_CYCLES + 2)
      else $error("op length wrong");
endmodule // boot_map_asserts

bind boot_section_address_map boot_map_asserts #(.VARIANT(VARIANT), .PROG_CYCLES(PROG_CYCLES))
   i_chk (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BOOT_SIZE_FUSE_HI_I(BOOT_SIZE_FUSE_HI_I),
   .BOOT_SIZE_FUSE_LO_I(BOOT_SIZE_FUSE_LO_I), .FETCH_ADDR_I(FETCH_ADDR_I),
   .FETCH_BLOCKED_O(FETCH_BLOCKED_O), .CORE_HALT_O(CORE_HALT_O),
   .BOOT_RESET_ADDR_O(BOOT_RESET_ADDR_O), .FLASH_ERASE_O(FLASH_ERASE_O),
   .FLASH_WRITE_O(FLASH_WRITE_O), .FLASH_PAGE_O(FLASH_PAGE_O));

// file: sim/core_model.sv
module core_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   output logic             ee_busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
      ee_busy_o = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask
   // Command then store back to back, so the store lands inside the arming window
   task automatic spm(input logic [4:0] cmd);
      logic [31:0] r;
      logic        e;
      do xfer(1'b0, boot_map_pkg::ADDR_CTRL, 32'h0, r, e); while (r[0]);
      // An EEPROM write is pending at first; poll its status flag until it drops
      ee_busy_o <= 1'b1;
      do begin
         xfer(1'b0, boot_map_pkg::ADDR_STATUS, 32'h0, r, e);
         ee_busy_o <= 1'b0;
      end while (r[boot_map_pkg::STATUS_EEPROM]);
      xfer(1'b1, boot_map_pkg::ADDR_CTRL, {27'h0, cmd}, r, e);
      xfer(1'b1, boot_map_pkg::ADDR_STORE, 32'h0, r, e);
   endtask
endmodule // core_model

// file: sim/boot_section_address_map_bench.sv
module boot_section_address_map_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 20;
   logic        clk, rstn, fhi, flo, psel, pen, pwr, pready, perr, blocked, halt, erase, wrt;
   logic        ee, e;
   logic [7:0]  paddr, page;
   logic [31:0] pwdata, prdata, r, d;
   logic [15:0] fetch, boot;
   int          errors, n_checks, pg, w;
   core_model i_core (.clk_i(clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(perr),
      .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata),
      .ee_busy_o(ee));
   boot_section_address_map #(.PROG_CYCLES(PROG)) i_dut (.CLK_SYS_I(clk), .RSTN_I(rstn),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .BOOT_SIZE_FUSE_HI_I(fhi),
      .BOOT_SIZE_FUSE_LO_I(flo), .EEPROM_WRITE_IN_PROGRESS_I(ee), .FETCH_ADDR_I(fetch),
      .FETCH_BLOCKED_O(blocked), .CORE_HALT_O(halt), .BOOT_RESET_ADDR_O(boot),
      .FLASH_ERASE_O(erase), .FLASH_WRITE_O(wrt), .FLASH_PAGE_O(page));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      i_core.xfer(1'b1, a, v, r, e);
   endtask
   task automatic rdc(string what, logic [7:0] a, logic [31:0] exp);
      i_core.xfer(1'b0, a, 32'h0, r, e);
      chk(what, r, exp);
   endtask
   task automatic rst(logic [1:0] c);
      @(posedge clk);
      rstn <= 1'b0;
      fhi <= c[1];
      flo <= c[0];
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   // Model: boot start is section top minus the decoded boot size
   function automatic logic [15:0] exp_boot(int c);
      return 16'(32'h4000 - (256 << (3 - c)));
   endfunction
   initial begin
      errors = 0;
      n_checks = 0;
      {rstn, fhi, flo} = 3'b000;
      fetch = 16'h0000;
      w = $urandom(32'hA78EA65F);
      for (int c = 0; c < 4; c++) begin
         rst(2'(c));
         chk("boot", {16'h0, boot}, {16'h0, exp_boot(c)});
         rdc("status", boot_map_pkg::ADDR_STATUS, {10'h0, 2'h2, 2'h0, 2'(c), exp_boot(c)});
      end
      w = $urandom_range(63, 0);
      d = $urandom & 32'hFFFF;
      wr(boot_map_pkg::ADDR_POINTER, 32'(w << 1));
      wr(boot_map_pkg::ADDR_DATA, d);
      i_core.spm(boot_map_pkg::CMD_FILL);
      for (int b = 0; b < 2; b++) begin
         wr(boot_map_pkg::ADDR_POINTER, 32'((w << 1) | b));
         rdc("load", boot_map_pkg::ADDR_LOAD, b ? d[15:8] : d[7:0]);
      end
      pg = $urandom_range(223, 0);
      wr(boot_map_pkg::ADDR_POINTER, 32'(32'h8000 | (pg << 7) | ($urandom_range(63, 0) << 1)));
      i_core.spm(boot_map_pkg::CMD_ERASE);
      repeat (2) @(posedge clk);
      chk("page", page, pg);
      chk("erase", erase, 1);
      chk("halt", halt, 0);
      fetch <= 16'h37FF;
      repeat (2) @(posedge clk);
      chk("blocked", blocked, 1);
      fetch <= 16'h3800;
      repeat (2) @(posedge clk);
      chk("blocked", blocked, 0);
      rdc("ctrl", boot_map_pkg::ADDR_CTRL, 32'h43);
      do begin
         i_core.spm(boot_map_pkg::CMD_REENABLE);
         i_core.xfer(1'b0, boot_map_pkg::ADDR_CTRL, 32'h0, r, e);
      end while (r[boot_map_pkg::BIT_BUSY]);
      fetch <= 16'h0000;
      repeat (3) @(posedge clk);
      chk("blocked", blocked, 0);
      rdc("ctrl", boot_map_pkg::ADDR_CTRL, 32'h0);
      pg = $urandom_range(255, 224);
      wr(boot_map_pkg::ADDR_POINTER, 32'(pg << 7));
      i_core.spm(boot_map_pkg::CMD_WRITE);
      repeat (2) @(posedge clk);
      chk("halt", halt, 1);
      chk("write", wrt, 1);
      chk("page", page, pg);
      rdc("ctrl", boot_map_pkg::ADDR_CTRL, 32'h05);
      repeat (PROG + 2) @(posedge clk);
      chk("halt", halt, 0);
      rdc("ctrl", boot_map_pkg::ADDR_CTRL, 32'h0);
      // Armed without a store, then an illegal code
      for (int i = 0; i < 2; i++) begin
         wr(boot_map_pkg::ADDR_CTRL, i ? 32'h07 : 32'(boot_map_pkg::CMD_ERASE));
         repeat (5) @(posedge clk);
         rdc("ctrl", boot_map_pkg::ADDR_CTRL, 32'h0);
         chk("erase", erase, 0);
      end
      i_core.xfer(1'b0, 8'h18, 32'h0, r, e);
      chk("slverr", e, 1);
      stop_test();
   end
endmodule // boot_section_address_map_bench
